//--- cpr_ctrl_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpr_map.svh"

module cpr_ctrl_regs
    import cpr_pkg::*;
(
    // Clock, reset and freeze
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Comparator input routing
    output logic neg_input_source_sel,
    output logic [3:0] neg_ext_input_sel,
    output logic pos_from_amp_sel,
    output logic [3:0] pos_ext_input_sel,
    // Amplifier control
    output logic amp_power_down,
    output logic [3:0] amp_pos_input_sel,
    output logic amp_neg_ref_sel,
    output logic [1:0] amp_gain_sel,
    output logic [1:0] amp_mode_sel,
    // Port 2 pin data
    output logic [1:0] port2_pin_data,
    // PWM control
    output cpr_clk_src_e pwm_group_clk_sel,
    output cpr_clk_src_e pwm_zero_clk_sel,
    output logic pwm_group_enable,
    output logic pwm_zero_enable,
    input wire logic pwm_zero_pos_in,
    input wire logic pwm_zero_neg_in,
    output logic pwm_zero_pos_out,
    output logic pwm_zero_neg_out,
    // Pin modes of port 1 pins 0..3
    output logic [1:0] port1_pin_mode [4],
    // Comparator raw output and its debounced level
    input wire logic cmp_raw_output,
    output logic cmp_debounced
);

    // ****************************************************
    // Decode functions
    // ****************************************************
    // One-hot select of four inputs; top code bit opens all
    function automatic logic [3:0] sel4(input logic [2:0] code);
        return code[2] ? 4'h0 : 4'h1 << code[1:0];
    endfunction

    // One-hot select of three pins plus ground (bit 3)
    function automatic logic [3:0] pin_or_gnd(input logic [1:0] code);
        return 4'h1 << code;
    endfunction

    // Clock source code to decoded source; 00 and 01 both system
    function automatic cpr_clk_src_e clk_src(input logic [1:0] code);
        case (code)
            2'h2: return CPR_CLK_RC;
            2'h3: return CPR_CLK_RC2;
            default: return CPR_CLK_SYS;
        endcase
    endfunction

    // Debounce length for a select code, zero for none
    function automatic logic [4:0] db_len(input logic [1:0] code);
        case (code)
            2'h1: return `CPR_DB_LEN_1;
            2'h2: return `CPR_DB_LEN_2;
            2'h3: return `CPR_DB_LEN_3;
            default: return 5'h00;
        endcase
    endfunction

    // ****************************************************
    // APB decode
    // ****************************************************
    logic [7:0] cmp_sel_q; // Comparator input select
    logic [7:0] amp_q; // Amplifier control
    logic [7:0] port2_q; // Port 2 data and spare bits
    logic [7:0] pwm_q; // PWM clock, enable and mask data
    logic [7:0] pin_mode_q; // Port 1 low pin modes
    logic [7:0] aux_q; // Debounce, mask enable, clear
    logic [7:0] cmp_sel_d;
    logic [7:0] amp_d;
    logic [7:0] port2_d;
    logic [7:0] pwm_d;
    logic [7:0] pin_mode_d;
    logic [7:0] aux_d;
    logic pready_q; // Second access cycle answers
    logic [31:0] prdata_q; // Captured read data
    logic pslverr_q; // Unmapped address answer
    logic [7:0] idx; // Register index from the address
    logic hit; // Address maps to a register
    logic acc; // First access cycle
    logic wr; // Write takes effect this edge
    logic [7:0] rd_mux; // Read data of addressed register

    assign idx = paddr[9:2];
    assign acc = psel && penable && !pready_q;
    assign wr = psel && penable && pready_q && pwrite && hit && pstrb[0];

    // Address match and read selection
    always_comb begin
        hit = 1'b1;
        rd_mux = 8'h00;
        if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0) begin
            // Misaligned or out of range
            hit = 1'b0;
        end else begin
            case (idx)
                `CPR_IDX_CMP_SEL: rd_mux = cmp_sel_q;
                `CPR_IDX_AMP: rd_mux = amp_q;
                `CPR_IDX_PORT2: rd_mux = port2_q;
                `CPR_IDX_PWM: rd_mux = pwm_q;
                `CPR_IDX_PIN_MODE: rd_mux = pin_mode_q;
                `CPR_IDX_AUX: begin
                    // Live debounced level in the top bit
                    rd_mux = aux_q;
                    rd_mux[`CPR_AUX_DEB_STATE] = cmp_debounced;
                end
                default: hit = 1'b0;
            endcase
        end
    end

    // Next register values from a bus write
    always_comb begin
        cmp_sel_d = cmp_sel_q;
        amp_d = amp_q;
        port2_d = port2_q;
        pwm_d = pwm_q;
        pin_mode_d = pin_mode_q;
        aux_d = aux_q;
        if (wr) begin
            case (idx)
                `CPR_IDX_CMP_SEL: cmp_sel_d = pwdata[7:0];
                `CPR_IDX_AMP: amp_d = pwdata[7:0];
                `CPR_IDX_PORT2: port2_d = pwdata[7:0];
                `CPR_IDX_PWM: pwm_d = pwdata[7:0];
                `CPR_IDX_PIN_MODE: pin_mode_d = pwdata[7:0];
                `CPR_IDX_AUX: aux_d = pwdata[7:0] & `CPR_AUX_RW_MASK;
                default: aux_d = aux_q;
            endcase
        end
    end

    // ****************************************************
    // APB answer: one wait cycle, then ready
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end else if (clk_en) begin
            // Ready pulses for one cycle per transfer
            pready_q <= acc;
            if (acc) begin
                prdata_q <= {24'h0, rd_mux};
                pslverr_q <= !hit;
            end
        end
    end

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    // ****************************************************
    // Register storage
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_sel_q <= `CPR_RST_CMP_SEL;
            amp_q <= `CPR_RST_AMP;
            port2_q <= `CPR_RST_PORT2;
            pwm_q <= `CPR_RST_PWM;
            pin_mode_q <= `CPR_RST_PIN_MODE;
            aux_q <= `CPR_RST_AUX;
        end else if (clk_en) begin
            cmp_sel_q <= cmp_sel_d;
            amp_q <= amp_d;
            port2_q <= port2_d;
            pwm_q <= pwm_d;
            pin_mode_q <= pin_mode_d;
            aux_q <= aux_d;
        end
    end

    // ****************************************************
    // Comparator and amplifier routing outputs
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            neg_input_source_sel <= 1'(`CPR_RST_CMP_SEL >> `CPR_CMP_NEG_SRC);
            neg_ext_input_sel <= 4'h0;
            pos_from_amp_sel <= 1'b0;
            pos_ext_input_sel <= 4'h0;
        end else if (clk_en) begin
            neg_input_source_sel <= cmp_sel_d[`CPR_CMP_NEG_SRC];
            // Top code bit leaves the input open
            neg_ext_input_sel <= sel4(
                cmp_sel_d[`CPR_CMP_NEG_HI:`CPR_CMP_NEG_LO]);
            pos_from_amp_sel <= cmp_sel_d[`CPR_CMP_POS_AMP];
            pos_ext_input_sel <= sel4(
                cmp_sel_d[`CPR_CMP_POS_HI:`CPR_CMP_POS_LO]);
        end
    end

    // Amplifier power, input, reference, gain and mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp_power_down <= 1'b1;
            amp_pos_input_sel <= 4'h8;
            amp_neg_ref_sel <= 1'b0;
            amp_gain_sel <= 2'h3;
            amp_mode_sel <= 2'h0;
        end else if (clk_en) begin
            amp_power_down <= amp_d[`CPR_AMP_PD];
            amp_pos_input_sel <= pin_or_gnd(
                amp_d[`CPR_AMP_PIN_HI:`CPR_AMP_PIN_LO]);
            amp_neg_ref_sel <= amp_d[`CPR_AMP_NREF];
            amp_gain_sel <= amp_d[`CPR_AMP_GAIN_HI:`CPR_AMP_GAIN_LO];
            amp_mode_sel <= amp_d[`CPR_AMP_MODE_HI:`CPR_AMP_MODE_LO];
        end
    end

    // Port 2 pin data; upper bits stay internal
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port2_pin_data <= 2'h3;
        end else if (clk_en) begin
            port2_pin_data <= port2_d[`CPR_PORT2_PIN_HI:0];
        end
    end

    // ****************************************************
    // PWM control outputs
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_group_clk_sel <= CPR_CLK_SYS;
            pwm_zero_clk_sel <= CPR_CLK_SYS;
            pwm_group_enable <= 1'b0;
            pwm_zero_enable <= 1'b0;
        end else if (clk_en) begin
            pwm_group_clk_sel <= clk_src(
                pwm_d[`CPR_PWM_GRP_CK_HI:`CPR_PWM_GRP_CK_LO]);
            pwm_zero_clk_sel <= clk_src(
                pwm_d[`CPR_PWM_ZERO_CK_HI:`CPR_PWM_ZERO_CK_LO]);
            pwm_group_enable <= pwm_d[`CPR_PWM_GRP_EN];
            pwm_zero_enable <= pwm_d[`CPR_PWM_ZERO_EN];
        end
    end

    // PWM0 outputs, overridden by mask data on a masked clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_zero_pos_out <= 1'b0;
            pwm_zero_neg_out <= 1'b0;
        end else if (clk_en) begin
            if (aux_q[`CPR_AUX_CLEAR] && aux_q[`CPR_AUX_MSK_EN]) begin
                // Override permitted and requested
                pwm_zero_neg_out <= pwm_q[`CPR_PWM_NEG_MSK];
                pwm_zero_pos_out <= pwm_q[`CPR_PWM_POS_MSK];
            end else begin
                // Pass the PWM unit through
                pwm_zero_neg_out <= pwm_zero_neg_in;
                pwm_zero_pos_out <= pwm_zero_pos_in;
            end
        end
    end

    // ****************************************************
    // Port 1 pin modes, one field per pin
    // ****************************************************
    for (genvar g = 0; g < 4; g++) begin : g_pin_mode
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                port1_pin_mode[g] <= 2'h1;
            end else if (clk_en) begin
                port1_pin_mode[g] <= pin_mode_d[2*g+1 -: 2];
            end
        end
    end

    // ****************************************************
    // Comparator raw output debounce
    // ****************************************************
    logic [4:0] db_cnt_q; // Cycles the raw level has differed
    logic [4:0] db_need; // Length for the selected code
    assign db_need = db_len(aux_q[`CPR_AUX_DB_HI:`CPR_AUX_DB_LO]);
    // New level is taken once it has held for the length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            db_cnt_q <= 5'h0;
            cmp_debounced <= 1'b0;
        end else if (clk_en) begin
            if (cmp_raw_output == cmp_debounced) begin
                db_cnt_q <= 5'h0;
            end else if (db_need == 5'h0 ||
                         db_cnt_q == db_need - 5'h1) begin
                // No debounce, or the level has held long enough
                cmp_debounced <= cmp_raw_output;
                db_cnt_q <= 5'h0;
            end else begin
                db_cnt_q <= db_cnt_q + 5'h1;
            end
        end
    end

    // ****************************************************
    // Checks
    // ****************************************************
    neg_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        neg_ext_input_sel == sel4(cmp_sel_q[`CPR_CMP_NEG_HI:`CPR_CMP_NEG_LO]))
        else $error("negative comparator route mismatch");
    pos_src_a: assert property (@(posedge pclk) disable iff (!presetn)
        pos_from_amp_sel == cmp_sel_q[`CPR_CMP_POS_AMP] &&
        pos_ext_input_sel == sel4(cmp_sel_q[`CPR_CMP_POS_HI:`CPR_CMP_POS_LO]))
        else $error("positive comparator route mismatch");
    amp_ctrl_a: assert property (@(posedge pclk) disable iff (!presetn)
        amp_power_down == amp_q[`CPR_AMP_PD] &&
        amp_pos_input_sel ==
            pin_or_gnd(amp_q[`CPR_AMP_PIN_HI:`CPR_AMP_PIN_LO]))
        else $error("amplifier power or input mismatch");
    amp_gain_a: assert property (@(posedge pclk) disable iff (!presetn)
        {amp_gain_sel, amp_mode_sel, amp_neg_ref_sel} ==
        {amp_q[`CPR_AMP_GAIN_HI:`CPR_AMP_MODE_LO], amp_q[`CPR_AMP_NREF]})
        else $error("amplifier gain, mode or reference mismatch");
    port2_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && wr && idx == `CPR_IDX_PORT2 |=>
        port2_q == $past(pwdata[7:0]) &&
        port2_pin_data == $past(pwdata[1:0]))
        else $error("port 2 write not taken");
    pwm_en_a: assert property (@(posedge pclk) disable iff (!presetn)
        pwm_group_enable == pwm_q[`CPR_PWM_GRP_EN] &&
        pwm_zero_enable == pwm_q[`CPR_PWM_ZERO_EN] &&
        pwm_zero_clk_sel == clk_src(pwm_q[3:2]))
        else $error("PWM enable or clock mismatch");
    mask_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && aux_q[`CPR_AUX_CLEAR] && aux_q[`CPR_AUX_MSK_EN] |=>
        pwm_zero_neg_out == $past(pwm_q[`CPR_PWM_NEG_MSK]) &&
        pwm_zero_pos_out == $past(pwm_q[`CPR_PWM_POS_MSK]))
        else $error("PWM0 mask data not driven");
    mask_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !aux_q[`CPR_AUX_MSK_EN] |=>
        pwm_zero_pos_out == $past(pwm_zero_pos_in))
        else $error("PWM0 override without mask enable");
    db_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && aux_q[1:0] == 2'h1 && $changed(cmp_debounced) |->
        $past(cmp_raw_output, 4) == cmp_debounced)
        else $error("debounce released too early");
    apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && acc |=> pready && prdata[7:0] == $past(rd_mux))
        else $error("APB answer late or wrong");
endmodule // cpr_ctrl_regs
`default_nettype wire

//--- cpr_map.svh
`ifndef CPR_MAP_SVH
`define CPR_MAP_SVH

// ****************************************************
// Register indices (byte address is four times these)
// ****************************************************
`define CPR_IDX_CMP_SEL 8'h9e
`define CPR_IDX_AMP 8'h9f
`define CPR_IDX_PORT2 8'ha0
`define CPR_IDX_PWM 8'ha1
`define CPR_IDX_PIN_MODE 8'ha2
`define CPR_IDX_AUX 8'ha8

// ****************************************************
// Reset values
// ****************************************************
`define CPR_RST_CMP_SEL 8'hf7
`define CPR_RST_AMP 8'hec
`define CPR_RST_PORT2 8'hff
`define CPR_RST_PWM 8'h00
`define CPR_RST_PIN_MODE 8'h55
`define CPR_RST_AUX 8'h00

// ****************************************************
// Field positions
// ****************************************************
`define CPR_CMP_NEG_SRC 7
`define CPR_CMP_NEG_HI 6
`define CPR_CMP_NEG_LO 4
`define CPR_CMP_POS_AMP 3
`define CPR_CMP_POS_HI 2
`define CPR_CMP_POS_LO 0
`define CPR_AMP_PD 7
`define CPR_AMP_PIN_HI 6
`define CPR_AMP_PIN_LO 5
`define CPR_AMP_NREF 4
`define CPR_AMP_GAIN_HI 3
`define CPR_AMP_GAIN_LO 2
`define CPR_AMP_MODE_HI 1
`define CPR_AMP_MODE_LO 0
`define CPR_PWM_GRP_CK_HI 7
`define CPR_PWM_GRP_CK_LO 6
`define CPR_PWM_GRP_EN 5
`define CPR_PWM_ZERO_EN 4
`define CPR_PWM_ZERO_CK_HI 3
`define CPR_PWM_ZERO_CK_LO 2
`define CPR_PWM_NEG_MSK 1
`define CPR_PWM_POS_MSK 0
`define CPR_AUX_DEB_STATE 7
`define CPR_AUX_MSK_EN 6
`define CPR_AUX_CLEAR 5
`define CPR_AUX_DB_HI 1
`define CPR_AUX_DB_LO 0
`define CPR_AUX_RW_MASK 8'h63
`define CPR_PORT2_PIN_HI 1

// ****************************************************
// Debounce lengths in system clock cycles
// ****************************************************
`define CPR_DB_LEN_1 5'h04
`define CPR_DB_LEN_2 5'h08
`define CPR_DB_LEN_3 5'h10

`endif

//--- cpr_pkg.sv
`default_nettype none
// ****************************************************
// Types shared by the control register bank
// ****************************************************
package cpr_pkg;
    // Decoded PWM clock source
    typedef enum logic [1:0] {
        CPR_CLK_SYS,
        CPR_CLK_RC,
        CPR_CLK_RC2
    } cpr_clk_src_e;
endpackage
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
    import cpr_pkg::*;
;
    // ****************************************************
    // Stimulus, expectations and design instance
    // ****************************************************
    typedef struct {logic rd; logic [31:0] d; logic e;} cpr_note_s;
    localparam logic [11:0] adr_cmp = 12'h278; // Comparator routing
    localparam logic [11:0] adr_amp = 12'h27c; // Amplifier control
    localparam logic [11:0] adr_p2 = 12'h280; // Port 2 data
    localparam logic [11:0] adr_pwm = 12'h284; // PWM control
    localparam logic [11:0] adr_pin = 12'h288; // Pin modes
    localparam logic [11:0] adr_aux = 12'h2a0; // Mask, clear, debounce
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic neg_input_source_sel, pos_from_amp_sel, amp_power_down;
    logic [3:0] neg_ext_input_sel, pos_ext_input_sel, amp_pos_input_sel;
    logic amp_neg_ref_sel, pwm_group_enable, pwm_zero_enable;
    logic [1:0] amp_gain_sel, amp_mode_sel, port2_pin_data;
    cpr_clk_src_e pwm_group_clk_sel, pwm_zero_clk_sel;
    logic pwm_zero_pos_in, pwm_zero_neg_in, pwm_zero_pos_out;
    logic pwm_zero_neg_out, cmp_raw_output, cmp_debounced;
    logic [1:0] port1_pin_mode [4];
    cpr_note_s notes [$]; // Expected answers, oldest first
    int n_mismatch = 0;
    int n_checks = 0;

    cpr_ctrl_regs cpr_ctrl_regs_i (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .neg_input_source_sel(neg_input_source_sel),
        .neg_ext_input_sel(neg_ext_input_sel),
        .pos_from_amp_sel(pos_from_amp_sel),
        .pos_ext_input_sel(pos_ext_input_sel),
        .amp_power_down(amp_power_down),
        .amp_pos_input_sel(amp_pos_input_sel),
        .amp_neg_ref_sel(amp_neg_ref_sel), .amp_gain_sel(amp_gain_sel),
        .amp_mode_sel(amp_mode_sel), .port2_pin_data(port2_pin_data),
        .pwm_group_clk_sel(pwm_group_clk_sel),
        .pwm_zero_clk_sel(pwm_zero_clk_sel),
        .pwm_group_enable(pwm_group_enable),
        .pwm_zero_enable(pwm_zero_enable),
        .pwm_zero_pos_in(pwm_zero_pos_in), .pwm_zero_neg_in(pwm_zero_neg_in),
        .pwm_zero_pos_out(pwm_zero_pos_out),
        .pwm_zero_neg_out(pwm_zero_neg_out),
        .port1_pin_mode(port1_pin_mode), .cmp_raw_output(cmp_raw_output),
        .cmp_debounced(cmp_debounced)
    );

    // 50 MHz system clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ****************************************************
    // Helpers
    // ****************************************************
    // Prints counts and verdict, then stops
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One comparison
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; the answer is noted for the monitor
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       input logic [31:0] er, input logic ee);
        int k;
        notes.push_back('{~wr, er, ee});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 50) begin
            n_mismatch++;
            $display("unexpected pready: expected 1 seen timeout");
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Write a register with random upper bits, then read it back
    task automatic wr_rd(input logic [11:0] a, input logic [7:0] v);
        apb(1'b1, a, {24'($urandom), v}, 4'hf, 32'h0, 1'b0);
        apb(1'b0, a, 32'h0, 4'h0, {24'h0, v}, 1'b0);
    endtask

    // Expected one-hot routing of a 3-bit input code
    function automatic logic [3:0] onehot(input logic [2:0] c);
        return c[2] ? 4'h0 : 4'h1 << c[1:0];
    endfunction

    // Expected clock source of a 2-bit code
    function automatic logic [1:0] clk_of(input logic [1:0] c);
        return (c < 2'h2) ? 2'h0 : ((c == 2'h2) ? 2'h1 : 2'h2);
    endfunction

    // PWM0 outputs against mask data or delayed inputs
    task automatic pwm_walk(input logic [1:0] m, input logic masked);
        int j;
        logic [31:0] r;
        for (j = 0; j < 6; j++) begin
            r = $urandom;
            pwm_zero_pos_in <= r[0];
            pwm_zero_neg_in <= r[1];
            @(posedge pclk);
            @(negedge pclk);
            chk("pwm0 out", {30'h0, masked ? m : r[1:0]}, {30'h0,
                pwm_zero_neg_out, pwm_zero_pos_out});
            @(posedge pclk);
        end
    endtask

    // Debounce: a short glitch is ignored, a long change lands on time
    task automatic deb(input logic [1:0] code, input int len);
        int k;
        logic lv;
        apb(1'b1, adr_aux, {30'h0, code}, 4'hf, 32'h0, 1'b0);
        lv = cmp_debounced;
        if (len > 1) begin
            cmp_raw_output <= ~lv;
            repeat (len - 1) @(posedge pclk);
            cmp_raw_output <= lv;
            repeat (len + 2) @(posedge pclk);
            chk("debounce hold", {31'h0, lv}, {31'h0, cmp_debounced});
        end
        cmp_raw_output <= ~lv;
        // Count from the first edge that samples the new level
        @(posedge pclk);
        for (k = 1; k <= 40; k++) begin
            @(negedge pclk);
            if (cmp_debounced !== lv) break;
        end
        chk("debounce length", len, k);
        if (k > 40) begin
            complete_run();
        end
        @(posedge pclk);
        apb(1'b0, adr_aux, 32'h0, 4'h0, {24'h0, ~lv, 5'h0, code}, 1'b0);
    endtask

    // ****************************************************
    // Monitor: each answer against the oldest note
    // ****************************************************
    always @(posedge pclk) begin
        cpr_note_s n;
        if (pready === 1'b1) begin
            if (notes.size() == 0) begin
                chk("unnoted answer", 32'h0, 32'h1);
            end else begin
                n = notes.pop_front();
                if (n.rd) begin
                    chk("prdata", n.d, prdata);
                end
                chk("pslverr", {31'h0, n.e}, {31'h0, pslverr});
            end
        end
    end

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        int i;
        logic [7:0] v;
        logic [11:0] adrs [6];
        logic [7:0] rsts [6];
        adrs = '{adr_cmp, adr_amp, adr_p2, adr_pwm, adr_pin, adr_aux};
        rsts = '{8'hf7, 8'hec, 8'hff, 8'h00, 8'h55, 8'h00};
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        pwm_zero_pos_in = 1'b0;
        pwm_zero_neg_in = 1'b0;
        cmp_raw_output = 1'b0;
        void'($urandom(32'h7a1c72d9));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 6; i++) begin
            apb(1'b0, adrs[i], 32'h0, 4'h0, {24'h0, rsts[i]}, 1'b0);
        end
        chk("amp reset", 32'h30c, {22'h0, amp_power_down, amp_pos_input_sel,
            amp_neg_ref_sel, amp_gain_sel, amp_mode_sel});
        $display("test reset values done");
        for (i = 0; i < 8; i++) begin
            v = 8'($urandom);
            v[6:4] = i[2:0];
            v[2:0] = ~i[2:0];
            wr_rd(adr_cmp, v);
            chk("cmp route", {22'h0, v[7], onehot(v[6:4]), v[3],
                onehot(v[2:0])}, {22'h0, neg_input_source_sel,
                neg_ext_input_sel, pos_from_amp_sel,
                pos_ext_input_sel});
        end
        for (i = 0; i < 64; i++) begin
            v = 8'($urandom);
            v[6:5] = i[1:0];
            v[3:2] = i[3:2];
            v[1:0] = i[5:4];
            wr_rd(adr_amp, v);
            chk("amp ctrl", {22'h0, v[7], 4'h1 << v[6:5], v[4:0]},
                {22'h0, amp_power_down, amp_pos_input_sel, amp_neg_ref_sel,
                amp_gain_sel, amp_mode_sel});
        end
        for (i = 0; i < 16; i++) begin
            v = 8'($urandom);
            v[7:6] = i[1:0];
            v[3:2] = i[3:2];
            wr_rd(adr_pwm, v);
            chk("pwm ctrl", {26'h0, clk_of(v[7:6]), clk_of(v[3:2]), v[5:4]},
                {26'h0, pwm_group_clk_sel, pwm_zero_clk_sel,
                pwm_group_enable, pwm_zero_enable});
            wr_rd(adr_p2, ~v);
            chk("port2 pins", {30'h0, ~v[1:0]}, {30'h0, port2_pin_data});
            wr_rd(adr_pin, v);
            chk("pin modes", {24'h0, v}, {24'h0, port1_pin_mode[3],
                port1_pin_mode[2], port1_pin_mode[1],
                port1_pin_mode[0]});
        end
        $display("test field decode done");
        apb(1'b1, adr_pin, 32'h0, 4'he, 32'h0, 1'b0);
        apb(1'b0, adr_pin, 32'h0, 4'h0, {24'h0, v}, 1'b0);
        apb(1'b1, 12'h2a4, 32'hff, 4'hf, 32'h0, 1'b1);
        apb(1'b0, 12'h2a4, 32'h0, 4'h0, 32'h0, 1'b1);
        apb(1'b0, 12'h279, 32'h0, 4'h0, 32'h0, 1'b1);
        apb(1'b0, 12'he78, 32'h0, 4'h0, 32'h0, 1'b1);
        apb(1'b1, adr_aux, 32'hff, 4'hf, 32'h0, 1'b0);
        apb(1'b0, adr_aux, 32'h0, 4'h0, 32'h63, 1'b0);
        $display("test refused accesses done");
        apb(1'b1, adr_pwm, 32'h2, 4'hf, 32'h0, 1'b0);
        pwm_walk(2'b10, 1'b1);
        apb(1'b1, adr_pwm, 32'h1, 4'hf, 32'h0, 1'b0);
        pwm_walk(2'b01, 1'b1);
        apb(1'b1, adr_aux, 32'h40, 4'hf, 32'h0, 1'b0);
        pwm_walk(2'b00, 1'b0);
        apb(1'b1, adr_aux, 32'h20, 4'hf, 32'h0, 1'b0);
        pwm_walk(2'b00, 1'b0);
        $display("test pwm0 mask done");
        deb(2'h0, 1);
        deb(2'h1, 4);
        deb(2'h2, 8);
        deb(2'h3, 16);
        $display("test debounce done");
        // Clock enable low freezes the debounce counter
        clk_en <= 1'b0;
        cmp_raw_output <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("frozen debounce", 32'h0, {31'h0, cmp_debounced});
        clk_en <= 1'b1;
        $display("test clock enable done");
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, adr_pin, 32'h0, 4'h0, 32'h55, 1'b0);
        chk("notes left", 32'h0, notes.size());
        $display("test second reset done");
        complete_run();
    end
endmodule // tb

`default_nettype wire
